// File: rtl/interrupt_vector_priority.v
// Interrupt vectoring, priority selection and pin control with APB access.
`include "interrupt_vector_priority_defines.vh"

// What this block does
// [RULE1] Reset, clock monitor, watchdog take FFFE, FFFC, FFFA, never masked.
// [RULE2] Pin connect bit zero cuts pin request; one feeds FFF2, I-masked.
// [RULE3] Writing a vector low byte to top priority elevates that source.
// [RULE4] Elevation value equals vector low byte; each source owns a pair.
// [RULE5] Modulus counter underflow uses FFCC, elevated by CC, I and local.
// [RULE6] Pulse accumulator edge uses FFDA, elevated by DA, I and local.
// [RULE7] Serial transfer complete uses FFD8, elevated by D8, I and local.
// [RULE8] Clock lock and limp-home uses FFC2, elevated by C2, local gated.
// [RULE9] Second accumulator overflow uses FFCA, elevated by CA.
// [RULE10] Pin control resets edge 0, connect 1, delay 1; low bits zero.
// [RULE11] Edge bit zero means low level, one means falling edges only.
// [RULE12] Edge bit: normal once; special any time but first write ignored.
// [RULE13] Connect bit is writable and readable at any time in any mode.
// [RULE14] Delay bit one waits 4096 oscillator cycles leaving halt.
// [RULE15] Delay bit: write once in normal modes, any time in special.
// [RULE16] Top priority reads any time, writes only with I mask set.
// [RULE17] Unimplemented or above F2 value makes the pin top priority.
// [RULE18] Default order follows vector address, higher address wins.
// [RULE19] Elevation leaves others' order and all vector addresses alone.
// [RULE20] Elevated source still obeys I mask and its local enable.
// [RULE21] Highest pending allowed vector is presented every clock cycle.
module interrupt_vector_priority (
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Core status.
  input wire core_i_mask,
  input wire core_x_mask,
  input wire special_mode,
  // Non-maskable sources.
  input wire clock_monitor_fail,
  input wire watchdog_fail,
  input wire illegal_opcode,
  input wire software_trap_instruction,
  input wire nonmaskable_pin_request_n,
  // External maskable pin, active low, and edge latch clear.
  input wire pin_request_n,
  input wire pin_edge_ack,
  // Peripheral maskable requests, index k vectors at $FFF2 - 2k.
  input wire [33:0] periph_request,
  input wire [33:0] periph_enable,
  // Low-power halt.
  input wire osc_tick,
  input wire stop_request,
  output wire stop_busy,
  output wire stop_resume,
  // Vector to the core.
  output reg irq_pending,
  output reg [15:0] vector_address
);

  localparam N = `NUM_MASKABLE;

  reg pin_edge_select;
  reg pin_request_connect;
  reg stop_exit_delay_enable;
  reg edge_written;
  reg delay_written;
  reg [7:0] top_priority_select;
  reg [1:0] pin_sync;
  reg [1:0] nmi_sync;
  reg pin_prev;
  reg pin_edge_latch;
  reg [15:0] next_vector;
  reg next_pending;
  wire [N-1:0] allowed;
  wire pin_level;
  wire pin_req;
  wire wr;
  wire rd;
  wire [N-1:0] elev_hit;
  wire elev_valid;
  integer i;

  // Maps a low byte to a source index; index only valid if in range.
  function [5:0] byte_to_index;
    input [7:0] b;
    reg [7:0] d;
    begin
      d = `LOW_BYTE_TOP - b;
      byte_to_index = d[6:1];
    end
  endfunction

  // True when a low byte names an implemented maskable source.
  function implemented;
    input [7:0] b;
    begin
      implemented = (b <= `LOW_BYTE_TOP) && (b >= `LOW_BYTE_LAST) &&
        (b[0] == 1'b0);
    end
  endfunction

  // Zero wait-state slave; every access completes in the access phase.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // Pin inputs cross two flops before use.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_sync <= 2'b11;
      nmi_sync <= 2'b11;
      pin_prev <= 1'b1;
    end else begin
      pin_sync <= {pin_sync[0], pin_request_n};
      nmi_sync <= {nmi_sync[0], nonmaskable_pin_request_n};
      pin_prev <= pin_sync[1];
    end
  end

  // Falling edge latch; a new edge wins over a clear in the same cycle.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_edge_latch <= 1'b0;
    end else if (pin_prev && !pin_sync[1]) begin
      pin_edge_latch <= 1'b1; // [RULE11]
    end else if (pin_edge_ack || !pin_edge_select) begin
      pin_edge_latch <= 1'b0;
    end
  end

  assign pin_level = pin_edge_select ? pin_edge_latch : !pin_sync[1]; // [RULE11]
  assign pin_req = pin_request_connect && pin_level; // [RULE2]

  // Register writes with the mode-dependent write-once locks.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_edge_select <= 1'b0; // [RULE10]
      pin_request_connect <= 1'b1; // [RULE10]
      stop_exit_delay_enable <= 1'b1; // [RULE10]
      edge_written <= 1'b0;
      delay_written <= 1'b0;
      top_priority_select <= `TOP_PRIORITY_RESET;
    end else if (wr) begin
      if (paddr == `ADDR_PIN_CONTROL) begin
        pin_request_connect <= pwdata[`PIN_CONNECT_BIT]; // [RULE13]
        edge_written <= 1'b1;
        delay_written <= 1'b1;
        // Special mode drops only the very first write after reset.
        if (special_mode ? edge_written : !edge_written) begin
          pin_edge_select <= pwdata[`PIN_EDGE_BIT]; // [RULE12]
        end
        if (special_mode || !delay_written) begin
          stop_exit_delay_enable <= pwdata[`STOP_DELAY_BIT]; // [RULE15]
        end
      end else if (paddr == `ADDR_TOP_PRIORITY && core_i_mask) begin
        top_priority_select <= pwdata[7:0]; // [RULE16]
      end
    end
  end

  // Source allowed when requested, locally enabled and I mask clear.
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_allow
      if (g == 0) begin : gen_pin
        assign allowed[g] = pin_req && !core_i_mask; // [RULE2]
      end else begin : gen_periph
        // Peripheral sources, each at its own vector index.
        assign allowed[g] = periph_request[g] && periph_enable[g] &&
          !core_i_mask; // [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE20]
      end
      assign elev_hit[g] = (byte_to_index(top_priority_select) == g); // [RULE4]
    end
  endgenerate

  assign elev_valid = implemented(top_priority_select); // [RULE17]

  // Priority resolve: non-maskable first, then elevated, then by address.
  always @* begin
    next_pending = 1'b1;
    next_vector = `VEC_NONE;
    if (clock_monitor_fail) begin
      next_vector = `VEC_CLOCK_MONITOR; // [RULE1]
    end else if (watchdog_fail) begin
      next_vector = `VEC_WATCHDOG; // [RULE1]
    end else if (illegal_opcode) begin
      next_vector = `VEC_TRAP;
    end else if (software_trap_instruction) begin
      next_vector = `VEC_SOFT_TRAP;
    end else if (!nmi_sync[1] && !core_x_mask) begin
      next_vector = `VEC_NMI_PIN;
    end else begin
      next_pending = 1'b0;
      // Lowest index scanned last so the highest address wins.
      for (i = N - 1; i >= 0; i = i - 1) begin
        if (allowed[i]) begin
          next_pending = 1'b1;
          next_vector = `VEC_PIN - {9'h000, i[5:0], 1'b0}; // [RULE18]
        end
      end
      // Elevation only reorders; the vector address is still its own.
      if (elev_valid && |(allowed & elev_hit)) begin
        next_vector = {8'hff, top_priority_select}; // [RULE3] [RULE19]
      end
    end
  end

  // Vector output is re-evaluated and registered every cycle.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_pending <= 1'b0;
      vector_address <= `VEC_RESET; // [RULE1]
    end else begin
      irq_pending <= next_pending; // [RULE21]
      vector_address <= next_pending ? next_vector : `VEC_RESET;
    end
  end

  // Read data is captured in setup so it is stable in the access phase.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (paddr)
        `ADDR_PIN_CONTROL: prdata <= {24'h000000, pin_edge_select,
          pin_request_connect, stop_exit_delay_enable, 5'h00}; // [RULE10]
        `ADDR_TOP_PRIORITY: prdata <= {24'h000000, top_priority_select};
        `ADDR_CORE_CONTROL: prdata <= {28'h0000000, stop_busy,
          special_mode, core_x_mask, core_i_mask};
        `ADDR_VECTOR_STATUS: prdata <= {15'h0000, irq_pending,
          vector_address};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Halt exit timer honours the delay enable.
  stop_exit_timer #(
    .DELAY_CYCLES(`STOP_EXIT_CYCLES)
  ) u_stop_exit_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .osc_tick(osc_tick),
    .start(stop_request),
    .delay_enable(stop_exit_delay_enable), // [RULE14]
    .busy(stop_busy),
    .resume(stop_resume)
  );

endmodule // interrupt_vector_priority

// File: inc/interrupt_vector_priority_defines.vh
// Offsets, field positions, reset values, vectors and timing constants.
`ifndef INTERRUPT_VECTOR_PRIORITY_DEFINES_VH
`define INTERRUPT_VECTOR_PRIORITY_DEFINES_VH

// Printed offsets are register indices; byte address is four times these.
`define IDX_PIN_CONTROL 8'h1e
`define IDX_TOP_PRIORITY 8'h1f
`define ADDR_PIN_CONTROL 12'h078
`define ADDR_TOP_PRIORITY 12'h07c
// Own registers: core status inputs with halt busy, and vector status.
`define ADDR_CORE_CONTROL 12'h080
`define ADDR_VECTOR_STATUS 12'h084

// Pin control field positions and reset value.
`define PIN_EDGE_BIT 7
`define PIN_CONNECT_BIT 6
`define STOP_DELAY_BIT 5
`define PIN_CONTROL_RESET 8'h60
`define TOP_PRIORITY_RESET 8'hf2

// Core control fields.
`define CORE_IMASK_BIT 0
`define CORE_XMASK_BIT 1
`define CORE_SPECIAL_BIT 2
`define CORE_STOP_BIT 3

// Vector addresses.
`define VEC_RESET 16'hfffe
`define VEC_CLOCK_MONITOR 16'hfffc
`define VEC_WATCHDOG 16'hfffa
`define VEC_TRAP 16'hfff8
`define VEC_SOFT_TRAP 16'hfff6
`define VEC_NMI_PIN 16'hfff4
`define VEC_PIN 16'hfff2
`define VEC_NONE 16'h0000

// Maskable sources: index 0 is the pin at $F2, index k is $F2 - 2k.
`define NUM_MASKABLE 34
`define LOW_BYTE_TOP 8'hf2
`define LOW_BYTE_LAST 8'hb0

// Stop exit delay in oscillator-derived cycles.
`define STOP_EXIT_CYCLES 4096
`endif

// File: rtl/stop_exit_timer.v
// Oscillator start-up delay counter used when leaving low-power halt.
module stop_exit_timer #(
  parameter DELAY_CYCLES = 4096
) (
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // Control.
  input wire osc_tick,
  input wire start,
  input wire delay_enable,
  // Status.
  output wire busy,
  output reg resume
);

  reg [12:0] count;
  reg running;

  assign busy = running;

  // Counts oscillator ticks; without the delay bit it resumes at once.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 13'h0000;
      running <= 1'b0;
      resume <= 1'b0;
    end else begin
      resume <= 1'b0;
      if (start && !running) begin
        if (delay_enable) begin
          running <= 1'b1;
          count <= 13'h0000;
        end else begin
          resume <= 1'b1;
        end
      end else if (running && osc_tick) begin
        if (count == DELAY_CYCLES[12:0] - 13'h0001) begin
          running <= 1'b0;
          resume <= 1'b1;
        end else begin
          count <= count + 13'h0001;
        end
      end
    end
  end

endmodule // stop_exit_timer

// File: tb/interrupt_vector_priority_chk.sv
// Concurrent checks on the interrupt block's ports.
module ivp_chk (
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // Bus and request inputs.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire core_i_mask,
  input wire clock_monitor_fail,
  input wire watchdog_fail,
  input wire [33:0] periph_request,
  input wire [33:0] periph_enable,
  // Outputs toward the core.
  input wire stop_resume,
  input wire irq_pending,
  input wire [15:0] vector_address
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Bit 0 is the pin, so only peripheral bits count as open sources.
  sequence s_open;
    !core_i_mask && |(periph_request & periph_enable & 34'h3fffffffe);
  endsequence
  sequence s_ctl_read;
    psel && penable && !pwrite && paddr == 12'h078;
  endsequence
  clk_mon_a: assert property (
    clock_monitor_fail |=> irq_pending && vector_address == 16'hfffc
  ) else $error("clock monitor vector wrong");
  wdog_vec_a: assert property (
    watchdog_fail && !clock_monitor_fail |=> vector_address == 16'hfffa
  ) else $error("watchdog vector wrong");
  i_gate_a: assert property (
    core_i_mask |=> vector_address > 16'hfff2
  ) else $error("maskable vector with I set");
  open_pend_a: assert property (
    s_open |=> irq_pending
  ) else $error("open request not presented");
  vec_pair_a: assert property (
    irq_pending |-> !vector_address[0] && vector_address >= 16'hffb0
  ) else $error("vector off its pair");
  idle_vec_a: assert property (
    !irq_pending |-> vector_address == 16'hfffe
  ) else $error("idle vector wrong");
  ctl_bits_a: assert property (
    s_ctl_read |-> prdata[4:0] == 5'h0 && prdata[31:8] == 24'h0
  ) else $error("pin control spare bits set");
  resume_one_a: assert property (
    $rose(stop_resume) |=> !stop_resume
  ) else $error("resume longer than one cycle");
endmodule // ivp_chk

bind interrupt_vector_priority ivp_chk i_chk (.ref_clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .core_i_mask, .clock_monitor_fail,
  .watchdog_fail, .periph_request, .periph_enable, .stop_resume,
  .irq_pending, .vector_address);

// File: tb/source_model.sv
// Model of the core's I mask and the latched peripheral request flags.
module source_model (
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // Loads from the bench.
  input wire ld,
  input wire [33:0] rq_in,
  input wire [33:0] en_in,
  input wire im_in,
  // Toward the block.
  output logic [33:0] periph_request,
  output logic [33:0] periph_enable,
  output logic core_i_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  // Flags hold until software reloads them; I comes up set.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      periph_request <= '0;
      periph_enable <= '0;
      core_i_mask <= 1'b1;
    end else if (ld) begin
      periph_request <= rq_in;
      periph_enable <= en_in;
      core_i_mask <= im_in;
    end
  end
endmodule // source_model

// File: tb/interrupt_vector_priority_test.sv
// Self-checking bench for the interrupt vector and priority block.
module interrupt_vector_priority_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic clock_monitor_fail = 0, watchdog_fail = 0, illegal_opcode = 0;
  logic software_trap_instruction = 0, pin_request_n = 1, stop_request = 0;
  logic ld = 0, im_in = 1, im = 1, con = 1;
  logic special_mode = 0, pin_edge_ack = 0, core_x_mask = 1, edg = 0;
  logic nonmaskable_pin_request_n = 1, lat = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, r;
  logic [33:0] rq_in = '0, en_in = '0, rq = '0, en = '0, b;
  logic [7:0] hp = 8'hf2;
  logic [7:0] tbl [12] = '{8'hf0, 8'hcc, 8'hda, 8'hd8, 8'hc2, 8'hca,
    8'he4, 8'hb2, 8'hf4, 8'hf3, 8'hff, 8'ha0};
  wire pready, pslverr, core_i_mask, stop_busy, stop_resume, irq_pending;
  wire [31:0] prdata;
  wire [33:0] periph_request, periph_enable;
  wire [15:0] vector_address;
  integer num_errors = 0, tests_run = 0, seed = 32'he72c, i, n;

  // Free-running 20 ns clock.
  always #10 ref_clk = ~ref_clk;

  interrupt_vector_priority i_dut (.ref_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .core_i_mask,
    .core_x_mask, .special_mode, .clock_monitor_fail,
    .watchdog_fail, .illegal_opcode, .software_trap_instruction,
    .nonmaskable_pin_request_n, .pin_request_n, .pin_edge_ack,
    .periph_request, .periph_enable, .osc_tick(1'b1), .stop_request,
    .stop_busy, .stop_resume, .irq_pending, .vector_address);
  source_model i_src (.ref_clk, .resetn, .ld, .rq_in, .en_in, .im_in,
    .periph_request, .periph_enable, .core_i_mask);

  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bit 0 belongs to the pin, so random peripheral sets leave it clear.
  function automatic [33:0] rnd;
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    rnd = t[33:0] & 34'h3fffffffe;
  endfunction

  // Later assignments win, so the highest priority is applied last.
  function automatic [16:0] exp_vec;
    logic [33:0] m;
    m = rq & en;
    // In edge mode the pin counts from its latched falling edge.
    m[0] = con & (edg ? lat : !pin_request_n);
    exp_vec = {1'b0, 16'hfffe};
    for (int k = 33; k >= 0; k--) begin
      if (m[k] && !im) exp_vec = {1'b1, 16'hfff2 - 16'(2 * k)};
    end
    if (!im && !hp[0] && hp >= 8'hb0 && hp <= 8'hf2 && m[(8'hf2 - hp) >> 1])
      exp_vec = {1'b1, 8'hff, hp};
    if (!core_x_mask && !nonmaskable_pin_request_n)
      exp_vec = {1'b1, 16'hfff4};
    if (software_trap_instruction) exp_vec = {1'b1, 16'hfff6};
    if (illegal_opcode) exp_vec = {1'b1, 16'hfff8};
    if (watchdog_fail) exp_vec = {1'b1, 16'hfffa};
    if (clock_monitor_fail) exp_vec = {1'b1, 16'hfffc};
  endfunction

  task automatic chk_vec;
    chk_reg({15'h0, irq_pending, vector_address}, {15'h0, exp_vec()});
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrc(input logic [11:0] a, input logic [31:0] d, e);
    apb(1'b1, a, d);
    apb(1'b0, a, '0);
    chk_reg(r, e);
  endtask

  // Pins need sync stages, so the vector is compared four edges later.
  task automatic drive(input logic [3:0] nm, input logic [33:0] q, e,
      input logic iv);
    @(posedge ref_clk);
    {clock_monitor_fail, watchdog_fail, illegal_opcode,
      software_trap_instruction} <= nm;
    rq_in <= q;
    en_in <= e;
    im_in <= iv;
    ld <= 1'b1;
    rq = q;
    en = e;
    im = iv;
    @(posedge ref_clk);
    ld <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk_vec;
  endtask

  task automatic stopw;
    @(posedge ref_clk);
    stop_request <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      stop_request <= 1'b0;
      #1 n++;
    end while (stop_resume !== 1'b1 && n < 5000);
  endtask

  // Main sequence: registers, vectors, elevation, pin, halt exit.
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, 12'h078, '0);
    chk_reg(r, 32'h60);
    apb(1'b0, 12'h07c, '0);
    chk_reg(r, 32'hf2);
    apb(1'b0, 12'h040, '0);
    chk_reg(r, '0);
    drive(4'h0, '0, '0, 1'b0);
    wrc(12'h07c, 32'hf0, 32'hf2);
    for (i = 0; i < 4; i++) drive(4'hf >> i, rnd(), ~34'h0, i[0]);
    for (i = 0; i < 20; i++) drive(4'h0, rnd(), rnd(), 1'b0);
    for (i = 0; i < 12; i++) begin
      drive(4'h0, '0, '0, 1'b1);
      apb(1'b1, 12'h07c, {24'h0, tbl[i]});
      hp = tbl[i];
      b = 34'h1 << ((8'hf2 - hp) >> 1);
      drive(4'h0, rnd() | b, rnd() | b, 1'b0);
      drive(4'h0, rnd() | b, rnd() & ~b, 1'b0);
      drive(4'h0, rnd() | b, rnd() | b, 1'b1);
    end
    wrc(12'h078, 32'h5f, 32'h40);
    wrc(12'h078, 32'hff, 32'h40);
    wrc(12'h078, 32'h00, 32'h00);
    con = 1'b0;
    @(posedge ref_clk);
    pin_request_n <= 1'b0;
    drive(4'h0, '0, '0, 1'b0);
    wrc(12'h078, 32'h40, 32'h40);
    con = 1'b1;
    drive(4'h0, rnd(), rnd(), 1'b0);
    stopw;
    chk_reg({31'h0, n <= 2}, 32'h1);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    pin_request_n <= 1'b1;
    {rq, en, im, con, hp} = {68'h0, 1'b1, 1'b1, 8'hf2};
    stopw;
    chk_reg({31'h0, n >= 4096 && n <= 4099}, 32'h1);
    // Special mode: first edge write dropped, later ones taken.
    special_mode <= 1'b1;
    apb(1'b0, 12'h080, '0);
    chk_reg(r, 32'h7);
    wrc(12'h078, 32'h80, 32'h00);
    wrc(12'h078, 32'he0, 32'he0);
    edg = 1'b1;
    // A one-cycle low pulse must stay latched until acknowledged.
    @(posedge ref_clk);
    pin_request_n <= 1'b0;
    @(posedge ref_clk);
    pin_request_n <= 1'b1;
    lat = 1'b1;
    drive(4'h0, '0, '0, 1'b0);
    @(posedge ref_clk);
    pin_edge_ack <= 1'b1;
    @(posedge ref_clk);
    pin_edge_ack <= 1'b0;
    lat = 1'b0;
    drive(4'h0, '0, '0, 1'b0);
    // Non-maskable pin with X clear beats every maskable source.
    @(posedge ref_clk);
    core_x_mask <= 1'b0;
    nonmaskable_pin_request_n <= 1'b0;
    drive(4'h0, rnd(), rnd(), 1'b0);
    nonmaskable_pin_request_n <= 1'b1;
    drive(4'h0, '0, '0, 1'b1);
    complete_run;
  end

  // A hang ends the run as a failure well past the expected length.
  initial begin
    #1000000;
    num_errors++;
    complete_run;
  end
endmodule // interrupt_vector_priority_test
